// >>> rmsc_chk_asserts.sv
`timescale 1ns/100ps
module rmsc_chk
(
  input wire CLK_SYS,
  input wire RESET_N,
  input wire SHUTDOWN_PIN,
  input wire SPI_MISO_OE,
  input wire GPIO_OE_EN,
  input wire [6:0] STATE_CODE,
  input wire CRYSTAL_OSC_ON,
  input wire SYNTH_ON,
  input wire WAKEUP_TIMER_ON,
  input wire [7:0] CAL_WORD,
  input wire [7:0] CAL_WORD_READBACK,
  input wire WAKEUP_TIMER_RELOAD,
  input wire CIPHER_ENCRYPT,
  input wire TX_QUEUE_FLUSH,
  input wire SOFT_RESET
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESET_N);
  AST_CODE_LEGAL:
    assert property (STATE_CODE inside {7'h00, 7'h40, 7'h36, 7'h03,
      7'h0F, 7'h5F, 7'h1F}) else $error("illegal state code");
  // Three samples cover the two-stage pin synchroniser
  AST_SHDN_HIZ:
    assert property (SHUTDOWN_PIN [*3] |-> !GPIO_OE_EN && !SPI_MISO_OE)
    else $error("pins driven in shutdown");
  AST_STANDBY_OFF:
    assert property ((STATE_CODE == 7'h40) [*2] |-> !CRYSTAL_OSC_ON &&
      !SYNTH_ON && !WAKEUP_TIMER_ON) else $error("standby power wrong");
  AST_SLEEP_TIMER:
    assert property ((STATE_CODE == 7'h36) [*2] |-> WAKEUP_TIMER_ON &&
      !CRYSTAL_OSC_ON) else $error("sleep power wrong");
  AST_READY_XO:
    assert property ((STATE_CODE == 7'h03) [*2] |-> CRYSTAL_OSC_ON)
    else $error("crystal off in ready");
  AST_LOCK_CAL:
    assert property ((STATE_CODE == 7'h0F) [*2] |-> SYNTH_ON &&
      CAL_WORD_READBACK == $past(CAL_WORD)) else $error("lock readback");
  AST_SLEEP_FROM:
    assert property (STATE_CODE == 7'h36 && $past(STATE_CODE) != 7'h36
      |-> $past(STATE_CODE) == 7'h03) else $error("sleep not from ready");
  AST_TX_FROM:
    assert property (STATE_CODE == 7'h5F && $past(STATE_CODE) != 7'h5F
      |-> $past(STATE_CODE) == 7'h0F) else $error("tx not via lock");
  AST_ONE_STROBE:
    assert property ($onehot0({WAKEUP_TIMER_RELOAD, CIPHER_ENCRYPT,
      TX_QUEUE_FLUSH, SOFT_RESET})) else $error("strobes overlap");
  CV_SLEEP: cover property (STATE_CODE == 7'h36);
  CV_TX: cover property (STATE_CODE == 7'h0F ##1 STATE_CODE == 7'h5F);
  CV_PROTO: cover property (STATE_CODE == 7'h1F);
endmodule // rmsc_chk

bind rmsc_top rmsc_chk u_chk (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N),
  .SHUTDOWN_PIN(SHUTDOWN_PIN), .SPI_MISO_OE(SPI_MISO_OE),
  .GPIO_OE_EN(GPIO_OE_EN), .STATE_CODE(STATE_CODE),
  .CRYSTAL_OSC_ON(CRYSTAL_OSC_ON), .SYNTH_ON(SYNTH_ON),
  .WAKEUP_TIMER_ON(WAKEUP_TIMER_ON), .CAL_WORD(CAL_WORD),
  .CAL_WORD_READBACK(CAL_WORD_READBACK),
  .WAKEUP_TIMER_RELOAD(WAKEUP_TIMER_RELOAD),
  .CIPHER_ENCRYPT(CIPHER_ENCRYPT), .TX_QUEUE_FLUSH(TX_QUEUE_FLUSH),
  .SOFT_RESET(SOFT_RESET));

// >>> rmsc_defs.vh
// Behaviour
// - Shutdown pin held: all state cleared, GPIO and SPI pins released (hi-Z).
// - Leaving shutdown, controller enters READY with crystal reference on.
// - Shutdown to usable READY takes about 650 microseconds.
// - State code: STANDBY 40, SLEEP 36, READY 03, LOCK 0F, TX 5F.
// - READY, STANDBY, LOCK stable when entered by own command.
// - Other states leave when their timeout timer expires. Here SLEEP, TX and protocol wait for events or commands instead.
// - READY and LOCK pass through when reached indirectly.
// - STANDBY from READY: crystal, synth, wakeup timer off; data kept.
// - SLEEP accepted only in READY; wakeup timer runs, crystal off.
// - Wakeup from SLEEP with pending transmit enters TX automatically.
// - Transmit command accepted only in READY.
// - Response to TX: 125 us from STANDBY/SLEEP, 50 us from READY.
// - LOCK reached on lock detect or lock timeout, whichever first.
// - LOCK by its command waits for next command; cal word readable.
// - TX held until packet sent, direct-mode underflow, or abort.
// - After TX: again if persistent, else protocol, else READY.
// - Abort always honoured in TX; destination as after completion.
// - Further SPI accesses may follow in the same chip select.
// - Command acts at end of its transfer, not at chip-select rise.
// - Wakeup-timer reload accepted in any state; reloads from registers.
// - Sequence-counter load accepted in any state.
// - Cipher commands 6A to 6D accepted in any state.
// - Soft reset acts like power-on reset.
`ifndef RMSC_DEFS_VH
`define RMSC_DEFS_VH
`define RMSC_ST_STANDBY 7'h40
`define RMSC_ST_SLEEP 7'h36
`define RMSC_ST_READY 7'h03
`define RMSC_ST_LOCK 7'h0F
`define RMSC_ST_TX 7'h5F
`define RMSC_ST_PROTO 7'h1F
`define RMSC_ST_OFF 7'h00
`define RMSC_HDR 8'h80
`define RMSC_C_TX 8'h60
`define RMSC_C_READY 8'h62
`define RMSC_C_STANDBY 8'h63
`define RMSC_C_SLEEP 8'h64
`define RMSC_C_LOCK_FOR_TRANSMIT_CMD 8'h66
`define RMSC_C_ABORT 8'h67
`define RMSC_C_RELOAD 8'h68
`define RMSC_C_SEQ 8'h69
`define RMSC_C_ENC 8'h6A
`define RMSC_C_KEY 8'h6B
`define RMSC_C_DEC 8'h6C
`define RMSC_C_KEYDEC 8'h6D
`define RMSC_C_SOFT_RESET_CMD 8'h70
`define RMSC_C_FLUSH 8'h72
`define RMSC_CLK_MHZ 100
`define RMSC_T_WAKE_US 650
`define RMSC_T_XO_US 75
`define RMSC_T_SYN_US 50
`define RMSC_CYC_WAKE (`RMSC_T_WAKE_US * `RMSC_CLK_MHZ)
`define RMSC_CYC_XO (`RMSC_T_XO_US * `RMSC_CLK_MHZ)
`define RMSC_CYC_SYN (`RMSC_T_SYN_US * `RMSC_CLK_MHZ)
`endif

// >>> rmsc_host.sv
`timescale 1ns/100ps
module rmsc_host
(
  input wire clk,
  output logic sck,
  output logic cs_n,
  output logic mosi
);
  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // Header then code, MSB first, 80 ns bit time; hold keeps select low
  task xfer(input logic [15:0] f, input logic hold);
    integer i;
    begin
      @(negedge clk);
      cs_n = 1'b0;
      for (i = 15; i >= 0; i--)
      begin
        mosi = f[i];
        repeat (4) @(negedge clk);
        sck = 1'b1;
        repeat (4) @(negedge clk);
        sck = 1'b0;
      end
      if (!hold)
      begin
        repeat (4) @(negedge clk);
        cs_n = 1'b1;
        // Deselected line must not look like held data
        mosi = ~mosi;
      end
    end
  endtask
endmodule // rmsc_host

// >>> rmsc_spi_rx.v
`timescale 1ns/100ps
`include "rmsc_defs.vh"
module rmsc_spi_rx
(
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire sck,
  input wire cs_n,
  input wire mosi,
  output reg cmd_vld_r,
  output reg [7:0] cmd_r
);
  reg sck_d_r;
  reg [2:0] bit_cnt_r;
  reg [6:0] sh_r;
  reg hdr_ok_r;
  reg [1:0] byte_idx_r;
  wire rise = sck & ~sck_d_r;
  wire [7:0] byte_in = {sh_r, mosi};
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sck_d_r <= 1'b0;
      bit_cnt_r <= 3'h0;
      sh_r <= 7'h00;
      hdr_ok_r <= 1'b0;
      byte_idx_r <= 2'h0;
      cmd_vld_r <= 1'b0;
      cmd_r <= 8'h00;
    end
    else if (ce)
    begin
      sck_d_r <= sck;
      cmd_vld_r <= 1'b0;
      if (cs_n)
      begin
        bit_cnt_r <= 3'h0;
        byte_idx_r <= 2'h0;
        hdr_ok_r <= 1'b0;
      end
      else if (rise)
      begin
        sh_r <= byte_in[6:0];
        bit_cnt_r <= bit_cnt_r + 3'h1;
        if (bit_cnt_r == 3'h7)
        begin
          if (byte_idx_r == 2'h0)
          begin
            hdr_ok_r <= (byte_in == `RMSC_HDR);
            byte_idx_r <= 2'h1;
          end
          else if (byte_idx_r == 2'h1)
          begin
            // Act on the last bit, not on chip-select rise
            cmd_vld_r <= hdr_ok_r;
            cmd_r <= byte_in;
            byte_idx_r <= 2'h2;
          end
          // Later bytes of the same select are let pass untouched
        end
      end
    end
  end
endmodule // rmsc_spi_rx

// >>> rmsc_sync.v
`timescale 1ns/100ps
module rmsc_sync
#(
  parameter W = 3
)
(
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
    end
    else if (ce)
    begin
      s1_r <= d;
      s2_r <= s1_r;
    end
  end
  assign q = s2_r;
endmodule // rmsc_sync

// >>> rmsc_top.v
`timescale 1ns/100ps
`include "rmsc_defs.vh"
module rmsc_top
#(
  parameter CYC_WAKE = `RMSC_CYC_WAKE,
  parameter CYC_XO = `RMSC_CYC_XO,
  parameter CYC_SYN = `RMSC_CYC_SYN
)
(
  input wire CLK_SYS,
  input wire RESET_N,
  input wire CE,
  input wire SHUTDOWN_PIN,
  input wire SPI_SCK,
  input wire SPI_CS_N,
  input wire SPI_MOSI,
  output wire SPI_MISO_OE,
  output wire GPIO_OE_EN,
  input wire LOCK_DETECT,
  input wire LOCK_TIMEOUT,
  input wire PACKET_DONE,
  input wire DIRECT_MODE,
  input wire QUEUE_UNDERFLOW,
  input wire PERSISTENT_TX,
  input wire PROTOCOL_ACTIVE,
  input wire PROTOCOL_DONE,
  input wire WAKEUP_EVENT,
  input wire TX_PENDING,
  input wire [7:0] CAL_WORD,
  output reg [7:0] CAL_WORD_READBACK,
  output reg [6:0] STATE_CODE,
  output reg CRYSTAL_OSC_ON,
  output reg SYNTH_ON,
  output reg WAKEUP_TIMER_ON,
  output reg WAKEUP_TIMER_RELOAD,
  output reg SEQ_COUNTER_LOAD,
  output reg CIPHER_ENCRYPT,
  output reg CIPHER_KEYGEN,
  output reg CIPHER_DECRYPT,
  output reg CIPHER_KEYGEN_DECRYPT,
  output reg TX_QUEUE_FLUSH,
  output reg TX_START,
  output reg SOFT_RESET
);
  localparam S_OFF = 9'h001;
  localparam S_BOOT = 9'h002;
  localparam S_READY = 9'h004;
  localparam S_STBY = 9'h008;
  localparam S_SLEEP = 9'h010;
  localparam S_XOWAIT = 9'h020;
  localparam S_LOCK = 9'h040;
  localparam S_TX = 9'h080;
  localparam S_PROTO = 9'h100;
  wire [2:0] sync_q;
  wire shutdown_pin;
  wire sck_s;
  wire cs_n_s;
  wire mosi_s;
  wire [7:0] ld_q;
  wire cmd_vld;
  wire [7:0] cmd;
  reg [8:0] st_r;
  reg [8:0] st_nxt;
  reg [16:0] tmr_r;
  reg [16:0] tmr_nxt;
  reg lock_cmd_r;
  reg lock_cmd_nxt;
  reg tx_after_r;
  reg tx_after_nxt;
  reg sdn_s1_r;
  reg sdn_s2_r;
  reg int_rst_n_r;
  wire rst_n = RESET_N & int_rst_n_r;
  wire [8:0] post_tx = PERSISTENT_TX ? S_TX :
                       (PROTOCOL_ACTIVE ? S_PROTO : S_READY);
  wire [7:0] lin = {LOCK_DETECT, LOCK_TIMEOUT, PACKET_DONE, DIRECT_MODE,
                    QUEUE_UNDERFLOW, PROTOCOL_DONE, WAKEUP_EVENT,
                    TX_PENDING};
  // Shutdown sync on its own so it can hold the core in reset
  always @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      sdn_s1_r <= 1'b1;
      sdn_s2_r <= 1'b1;
      int_rst_n_r <= 1'b0;
    end
    else
    begin
      sdn_s1_r <= SHUTDOWN_PIN;
      sdn_s2_r <= sdn_s1_r;
      // Soft reset pulses the internal reset for one cycle
      int_rst_n_r <= ~sdn_s2_r & ~(SOFT_RESET & CE);
    end
  end
  assign shutdown_pin = sdn_s2_r;
  rmsc_sync #(.W(3)) u_spi_sync
  (
    .clk(CLK_SYS),
    .rst_n(rst_n),
    .ce(CE),
    // Select kept inverted so a cleared stage reads as deselected
    .d({SPI_SCK, ~SPI_CS_N, SPI_MOSI}),
    .q(sync_q)
  );
  assign sck_s = sync_q[2];
  assign cs_n_s = ~sync_q[1];
  assign mosi_s = sync_q[0];
  // Status inputs come from the analog side, so synchronise them too
  rmsc_sync #(.W(8)) u_in_sync
  (
    .clk(CLK_SYS),
    .rst_n(rst_n),
    .ce(CE),
    .d(lin),
    .q(ld_q)
  );
  rmsc_spi_rx u_spi
  (
    .clk(CLK_SYS),
    .rst_n(rst_n),
    .ce(CE),
    .sck(sck_s),
    .cs_n(cs_n_s),
    .mosi(mosi_s),
    .cmd_vld_r(cmd_vld),
    .cmd_r(cmd)
  );
  assign SPI_MISO_OE = ~shutdown_pin & ~cs_n_s;
  assign GPIO_OE_EN = ~shutdown_pin & rst_n;
  always @*
  begin
    st_nxt = st_r;
    tmr_nxt = (tmr_r != 17'h0) ? tmr_r - 17'h1 : 17'h0;
    lock_cmd_nxt = lock_cmd_r;
    tx_after_nxt = tx_after_r;
    case (st_r)
      S_OFF:
      begin
        st_nxt = S_BOOT;
        tmr_nxt = CYC_WAKE[16:0];
      end
      S_BOOT:
        if (tmr_r == 17'h0)
          st_nxt = S_READY;
      S_READY:
        if (tx_after_r)
        begin
          st_nxt = S_LOCK;
          tmr_nxt = CYC_SYN[16:0];
        end
        else if (cmd_vld)
        begin
          if (cmd == `RMSC_C_TX)
          begin
            st_nxt = S_LOCK;
            lock_cmd_nxt = 1'b0;
            tx_after_nxt = 1'b1;
            tmr_nxt = CYC_SYN[16:0];
          end
          else if (cmd == `RMSC_C_LOCK_FOR_TRANSMIT_CMD)
          begin
            st_nxt = S_LOCK;
            lock_cmd_nxt = 1'b1;
            tx_after_nxt = 1'b0;
            tmr_nxt = CYC_SYN[16:0];
          end
          else if (cmd == `RMSC_C_STANDBY)
            st_nxt = S_STBY;
          else if (cmd == `RMSC_C_SLEEP)
            st_nxt = S_SLEEP;
        end
      S_STBY, S_SLEEP:
        if (cmd_vld && cmd == `RMSC_C_READY)
        begin
          st_nxt = S_XOWAIT;
          tx_after_nxt = 1'b0;
          tmr_nxt = CYC_XO[16:0];
        end
        else if (st_r == S_SLEEP && ld_q[1] && ld_q[0])
        begin
          st_nxt = S_XOWAIT;
          tx_after_nxt = 1'b1;
          tmr_nxt = CYC_XO[16:0];
        end
      S_XOWAIT:
        if (tmr_r == 17'h0)
          st_nxt = S_READY;
      S_LOCK:
        if (lock_cmd_r)
        begin
          if (cmd_vld && cmd == `RMSC_C_READY)
          begin
            st_nxt = S_READY;
            lock_cmd_nxt = 1'b0;
          end
        end
        else if (ld_q[7] || ld_q[6] || tmr_r == 17'h0)
        begin
          st_nxt = S_TX;
          tx_after_nxt = 1'b0;
        end
      S_TX:
        if ((cmd_vld && cmd == `RMSC_C_ABORT) || ld_q[5] ||
            (ld_q[4] && ld_q[3]))
          st_nxt = post_tx;
      S_PROTO:
        if (ld_q[2])
          st_nxt = S_READY;
      default:
        st_nxt = S_OFF;
    endcase
  end
  always @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= S_OFF;
      tmr_r <= 17'h0;
      lock_cmd_r <= 1'b0;
      tx_after_r <= 1'b0;
      STATE_CODE <= `RMSC_ST_OFF;
      CRYSTAL_OSC_ON <= 1'b0;
      SYNTH_ON <= 1'b0;
      WAKEUP_TIMER_ON <= 1'b0;
      CAL_WORD_READBACK <= 8'h00;
      WAKEUP_TIMER_RELOAD <= 1'b0;
      SEQ_COUNTER_LOAD <= 1'b0;
      CIPHER_ENCRYPT <= 1'b0;
      CIPHER_KEYGEN <= 1'b0;
      CIPHER_DECRYPT <= 1'b0;
      CIPHER_KEYGEN_DECRYPT <= 1'b0;
      TX_QUEUE_FLUSH <= 1'b0;
      TX_START <= 1'b0;
      SOFT_RESET <= 1'b0;
    end
    else if (CE)
    begin
      st_r <= st_nxt;
      tmr_r <= tmr_nxt;
      lock_cmd_r <= lock_cmd_nxt;
      tx_after_r <= tx_after_nxt;
      if (st_r == S_LOCK)
        CAL_WORD_READBACK <= CAL_WORD;
      // Any-state commands as one-cycle strobes; others ignored
      WAKEUP_TIMER_RELOAD <= cmd_vld && cmd == `RMSC_C_RELOAD;
      SEQ_COUNTER_LOAD <= cmd_vld && cmd == `RMSC_C_SEQ;
      CIPHER_ENCRYPT <= cmd_vld && cmd == `RMSC_C_ENC;
      CIPHER_KEYGEN <= cmd_vld && cmd == `RMSC_C_KEY;
      CIPHER_DECRYPT <= cmd_vld && cmd == `RMSC_C_DEC;
      CIPHER_KEYGEN_DECRYPT <= cmd_vld && cmd == `RMSC_C_KEYDEC;
      TX_QUEUE_FLUSH <= cmd_vld && cmd == `RMSC_C_FLUSH;
      SOFT_RESET <= cmd_vld && cmd == `RMSC_C_SOFT_RESET_CMD;
      // Entry pulse only; a persistent repeat stays one burst
      TX_START <= (st_nxt == S_TX) && (st_r != S_TX);
      case (st_nxt)
        S_STBY: STATE_CODE <= `RMSC_ST_STANDBY;
        S_SLEEP: STATE_CODE <= `RMSC_ST_SLEEP;
        S_READY, S_XOWAIT: STATE_CODE <= `RMSC_ST_READY;
        S_LOCK: STATE_CODE <= `RMSC_ST_LOCK;
        S_TX: STATE_CODE <= `RMSC_ST_TX;
        S_PROTO: STATE_CODE <= `RMSC_ST_PROTO;
        default: STATE_CODE <= `RMSC_ST_OFF;
      endcase
      // Crystal off in standby and sleep; wakeup timer only in sleep
      CRYSTAL_OSC_ON <= ~(st_nxt == S_STBY || st_nxt == S_SLEEP ||
                          st_nxt == S_OFF);
      SYNTH_ON <= (st_nxt == S_LOCK || st_nxt == S_TX ||
                   st_nxt == S_PROTO);
      WAKEUP_TIMER_ON <= (st_nxt == S_SLEEP);
    end
  end
endmodule // rmsc_top

// >>> tb.sv
`timescale 1ns/100ps
module tb;
  localparam WK = 20;
  logic clk, rst_n, shdn, lk, lto, pd, dm, uf, ptx, pa, pdn, we, tp, clr;
  wire sck, cs_n, mosi, miso_oe, gpio_oe, xo, syn, wkt, txs;
  wire [6:0] st;
  wire [7:0] cal_rb, stb;
  logic [7:0] seen, cw;
  logic [7:0] codes [8];
  integer err_total, n_compared, i;
  integer n_txs = 0;
  rmsc_host u_host (.clk(clk), .sck(sck), .cs_n(cs_n), .mosi(mosi));
  // Lock wait long enough to tell pin lock apart from timer expiry
  rmsc_top #(.CYC_WAKE(WK), .CYC_XO(10), .CYC_SYN(200)) u_dut (
    .CLK_SYS(clk), .RESET_N(rst_n), .CE(1'b1), .SHUTDOWN_PIN(shdn),
    .SPI_SCK(sck), .SPI_CS_N(cs_n), .SPI_MOSI(mosi),
    .SPI_MISO_OE(miso_oe), .GPIO_OE_EN(gpio_oe), .LOCK_DETECT(lk),
    .LOCK_TIMEOUT(lto), .PACKET_DONE(pd), .DIRECT_MODE(dm),
    .QUEUE_UNDERFLOW(uf), .PERSISTENT_TX(ptx), .PROTOCOL_ACTIVE(pa),
    .PROTOCOL_DONE(pdn), .WAKEUP_EVENT(we), .TX_PENDING(tp),
    .CAL_WORD(cw), .CAL_WORD_READBACK(cal_rb), .STATE_CODE(st),
    .CRYSTAL_OSC_ON(xo), .SYNTH_ON(syn), .WAKEUP_TIMER_ON(wkt),
    .WAKEUP_TIMER_RELOAD(stb[7]), .SEQ_COUNTER_LOAD(stb[6]),
    .CIPHER_ENCRYPT(stb[5]), .CIPHER_KEYGEN(stb[4]),
    .CIPHER_DECRYPT(stb[3]), .CIPHER_KEYGEN_DECRYPT(stb[2]),
    .TX_QUEUE_FLUSH(stb[1]), .SOFT_RESET(stb[0]), .TX_START(txs));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) seen <= clr ? 8'h00 : (seen | stb);
  always @(posedge clk)
    if (txs === 1'b1)
      n_txs <= n_txs + 1;
  task chk(input logic [15:0] got, input logic [15:0] exp);
    begin
      n_compared++;
      if (got !== exp)
      begin
        err_total++;
        $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // Bounded wait so a stuck state machine cannot hang the run
  task wst(input logic [6:0] e);
    integer k;
    begin
      k = 0;
      while (st !== e && k < 400)
      begin
        @(negedge clk);
        k++;
      end
      chk(st, e);
    end
  endtask
  task cmd(input logic [7:0] c);
    begin
      clr = 1'b1;
      @(negedge clk);
      clr = 1'b0;
      u_host.xfer({8'h80, c}, 1'b0);
    end
  endtask
  task tally_and_finish;
    begin
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  initial
  begin
    #200000;
    err_total++;
    tally_and_finish;
  end
  initial
  begin
    codes = '{8'h68, 8'h69, 8'h6A, 8'h6B, 8'h6C, 8'h6D, 8'h72, 8'h70};
    {rst_n, shdn, lk, lto, pd, dm, uf} = 7'h00;
    {ptx, pa, pdn, we, tp} = 5'h00;
    clr = 1'b1;
    cw = 8'hA5;
    err_total = 0;
    n_compared = 0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (WK - 4) @(negedge clk);
    chk(st, 7'h00);
    wst(7'h03);
    chk({gpio_oe, xo}, 2'h3);
    shdn = 1'b1;
    repeat (4) @(negedge clk);
    chk({gpio_oe, miso_oe, st}, 9'h000);
    shdn = 1'b0;
    wst(7'h03);
    $display("test power done");
    u_host.xfer(16'h8063, 1'b1);
    wst(7'h40);
    chk(miso_oe, 1'h1);
    u_host.xfer(16'hFFFF, 1'b0);
    chk({xo, syn, wkt, st}, {3'h0, 7'h40});
    cmd(8'h60);
    cmd(8'h64);
    repeat (20) @(negedge clk);
    chk(st, 7'h40);
    cmd(8'h62);
    wst(7'h03);
    u_host.xfer(16'h8163, 1'b0);
    repeat (20) @(negedge clk);
    chk(st, 7'h03);
    $display("test standby done");
    cmd(8'h66);
    wst(7'h0F);
    lk = 1'b1;
    repeat (30) @(negedge clk);
    chk({syn, cal_rb, st}, {1'h1, 8'hA5, 7'h0F});
    cw = 8'h3C;
    repeat (4) @(negedge clk);
    chk(cal_rb, 8'h3C);
    cmd(8'h62);
    wst(7'h03);
    cmd(8'h60);
    chk(st, 7'h5F);
    pa = 1'b1;
    cmd(8'h67);
    wst(7'h1F);
    pdn = 1'b1;
    wst(7'h03);
    {lk, pa, pdn, ptx} = 4'h1;
    cmd(8'h60);
    wst(7'h5F);
    pd = 1'b1;
    repeat (30) @(negedge clk);
    chk(st, 7'h5F);
    ptx = 1'b0;
    wst(7'h03);
    pd = 1'b0;
    $display("test lock tx done");
    cmd(8'h64);
    wst(7'h36);
    chk(wkt, 1'h1);
    {we, tp} = 2'h3;
    wst(7'h5F);
    {we, tp, pd} = 3'h1;
    wst(7'h03);
    pd = 1'b0;
    lto = 1'b1;
    cmd(8'h60);
    chk(st, 7'h5F);
    uf = 1'b1;
    repeat (20) @(negedge clk);
    chk(st, 7'h5F);
    dm = 1'b1;
    wst(7'h03);
    {lto, uf, dm} = 3'h0;
    chk(n_txs, 16'h0004);
    $display("test sleep done");
    for (i = 0; i < 8; i++)
    begin
      cmd(codes[i]);
      repeat (4) @(negedge clk);
      chk(seen, 8'h80 >> i);
    end
    chk(st, 7'h00);
    wst(7'h03);
    $display("test strobes done");
    tally_and_finish;
  end
endmodule // tb
